// file: dv/icf_checker_properties.sv
`timescale 1ns/1ps
`include "icf_defines.svh"

module icf_checker (
    input logic                     clk,
    input logic                     rstn,
    input logic [11:0]              paddr,
    input logic                     psel,
    input logic                     penable,
    input logic                     pwrite,
    input logic [31:0]              pwdata,
    input logic [31:0]              prdata,
    input logic                     pready,
    input logic                     pslverr,
    input logic                     irq_ack,
    input icf_pkg::icf_request_type irq_req,
    input logic [7:0]               pullup_en
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    // ==========
    // Bus answers
    property p_rdy;
        psel && !penable |=> pready;
    endproperty
    a_rdy: assert property (p_rdy) else $error("ready missing in access");
    property p_rdy_one;
        pready |=> !pready;
    endproperty
    a_rdy_one: assert property (p_rdy_one) else $error("ready longer than one cycle");
    property p_err;
        pready |-> pslverr == (paddr[1:0] != 2'b00 || paddr > `ICF_ADDR_VECTOR);
    endproperty
    a_err: assert property (p_err) else $error("error response wrong");
    property p_ep_zero;
        pready && !pwrite && paddr == `ICF_ADDR_EDGE_PRIO |-> (prdata & 32'hFFFFFF0A) == 32'h0;
    endproperty
    a_ep_zero: assert property (p_ep_zero) else $error("edge reg spare bits set");
    property p_xp_zero;
        pready && !pwrite && paddr == `ICF_ADDR_EXT_PINS |-> (prdata & 32'hFFFFFF24) == 32'h0;
    endproperty
    a_xp_zero: assert property (p_xp_zero) else $error("pin reg spare bits set");

    // ==========
    // Pull-ups and requests
    property p_pullup;
        pready && pwrite && paddr == `ICF_ADDR_EDGE_PRIO && pwdata[7] |=> ##[0:1] pullup_en == 8'h00;
    endproperty
    a_pullup: assert property (p_pullup) else $error("pull-ups not disabled");
    property p_hi_vec;
        irq_req.request && irq_req.high_priority |-> irq_req.vector == `ICF_VEC_HIGH;
    endproperty
    a_hi_vec: assert property (p_hi_vec) else $error("high vector wrong");
    property p_ack;
        irq_ack && irq_req.request && irq_req.high_priority |=> !irq_req.request;
    endproperty
    a_ack: assert property (p_ack) else $error("request kept after ack");
endmodule // icf_checker

bind icf_interrupt_flags icf_checker icf_checker_i (
    .clk(clk), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq_ack(irq_ack), .irq_req(irq_req), .pullup_en(pullup_en)
);

// file: dv/icf_core_model.sv
`timescale 1ns/1ps

// ==========
// Core side: answers a standing request after ack_delay cycles
module icf_core_model (
    input  logic                     clk,
    input  logic                     rstn,
    input  icf_pkg::icf_request_type irq_req,
    input  logic [3:0]               ack_delay,
    output logic                     irq_ack
);
    logic [3:0] wait_q;

    // Ack is one cycle; a request that goes away while waiting is never acked
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq_ack <= 1'b0;
            wait_q  <= 4'h0;
        end else if (irq_ack || !irq_req.request) begin
            irq_ack <= 1'b0;
            wait_q  <= 4'h0;
        end else if (wait_q >= ack_delay) begin
            irq_ack <= 1'b1;
        end else begin
            wait_q <= wait_q + 4'h1;
        end
    end
endmodule // icf_core_model

// file: dv/tb_interrupt_control_flags.sv
`timescale 1ns/1ps
`include "icf_defines.svh"

module tb_interrupt_control_flags;
    localparam logic [11:0] A_MAIN = `ICF_ADDR_MAIN;
    localparam logic [11:0] A_EP   = `ICF_ADDR_EDGE_PRIO;
    localparam logic [11:0] A_XP   = `ICF_ADDR_EXT_PINS;
    localparam logic [11:0] A_P1   = `ICF_ADDR_PERIPH_ONE;
    logic                     clk, rstn, psel, penable, pwrite, pready, pslverr, rd_err;
    logic                     port_read, rx_read, tx_write, pwm_mode, irq_ack, irq_return;
    logic [11:0]              paddr;
    logic [31:0]              pwdata, prdata, rd_data;
    logic [7:0]               port_latch, pullup_en;
    logic [3:0]               upper_port_pins, ack_delay;
    logic [2:0]               ext_pins;
    icf_pkg::icf_events_type  events;
    icf_pkg::icf_request_type irq_req;
    int                       fails, total_checks;

    icf_interrupt_flags icf_interrupt_flags_i (
        .clk(clk), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .events(events), .ext_pins(ext_pins),
        .upper_port_pins(upper_port_pins), .port_latch(port_latch), .port_read(port_read),
        .serial_rx_buffer_read(rx_read), .serial_tx_buffer_write(tx_write),
        .pulse_width_mode(pwm_mode), .irq_ack(irq_ack), .irq_return(irq_return),
        .irq_req(irq_req), .pullup_en(pullup_en)
    );
    icf_core_model icf_core_model_i (
        .clk(clk), .rstn(rstn), .irq_req(irq_req), .ack_delay(ack_delay), .irq_ack(irq_ack)
    );

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ==========
    // Shared tasks
    task automatic conclude();
        $display("checks=%0d fails=%0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= wr;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        // Read before this edge's updates land: what the slave showed at it
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        chk(32'(pready), 32'h1);
        if (pready !== 1'b1) conclude();
        rd_data = prdata;
        rd_err  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        acc(1'b0, a, 32'h0);
        chk(rd_data, exp);
    endtask

    task automatic pulse_ev(input logic [11:0] v);
        @(posedge clk);
        events <= icf_pkg::icf_events_type'(v);
        @(posedge clk);
        events <= '0;
    endtask

    task automatic wait_req(input logic lvl);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (irq_req.request !== lvl && n < 40);
        chk(32'(irq_req.request), 32'(lvl));
        if (irq_req.request !== lvl) conclude();
    endtask

    // ==========
    // Scenarios
    task automatic t_regs();
        rdc(A_MAIN, 32'h00);
        rdc(A_EP, 32'hF5);
        rdc(A_XP, 32'hC0);
        rdc(A_P1, 32'h10);
        chk(32'(pullup_en), 32'h00);
        acc(1'b1, A_EP, 32'h7F);
        rdc(A_EP, 32'h75);
        chk(32'(pullup_en), 32'hA5);
        acc(1'b1, A_EP, 32'hFF);
        repeat (2) @(posedge clk);
        chk(32'(pullup_en), 32'h00);
        acc(1'b1, A_XP, 32'hFF);
        rdc(A_XP, 32'hDB);
        acc(1'b1, A_MAIN, 32'h38);
        rdc(A_MAIN, 32'h38);
        acc(1'b1, A_MAIN, 32'h00);
        acc(1'b1, A_XP, 32'hC0);
        acc(1'b1, 12'h020, 32'hFF);
        chk(32'(rd_err), 32'h1);
        rdc(12'h020, 32'h0);
    endtask

    task automatic t_periph();
        int i;
        for (i = 0; i < 8; i++) begin
            if (i == 4 || i == 5) continue;
            pulse_ev(12'h001 << i);
            rdc(A_P1, 32'h10 | (32'h1 << i));
            acc(1'b1, A_P1, 32'h0);
            rdc(A_P1, 32'h10);
        end
        pulse_ev(12'h020);
        acc(1'b1, A_P1, 32'h0);
        rdc(A_P1, 32'h30);
        rx_read <= 1'b1;
        @(posedge clk);
        rx_read <= 1'b0;
        rdc(A_P1, 32'h10);
        tx_write <= 1'b1;
        @(posedge clk);
        tx_write <= 1'b0;
        acc(1'b1, A_P1, 32'h10);
        rdc(A_P1, 32'h00);
        pulse_ev(12'h010);
        rdc(A_P1, 32'h10);
        pwm_mode <= 1'b1;
        pulse_ev(12'h004);
        rdc(A_P1, 32'h10);
        pwm_mode <= 1'b0;
    endtask

    task automatic t_pins();
        int s;
        int p;
        pulse_ev(12'h800);
        rdc(A_MAIN, 32'h04);
        for (s = 0; s < 2; s++) begin
            acc(1'b1, A_EP, s ? 32'hF5 : 32'h85);
            for (p = 0; p < 3; p++) begin
                ext_pins <= s ? 3'b000 : 3'b111;
                // Let any hit from parking the pins land before the clear
                repeat (4) @(posedge clk);
                acc(1'b1, A_MAIN, 32'h00);
                acc(1'b1, A_XP, 32'hC0);
                ext_pins[p] <= s[0];
                rdc(A_MAIN, p == 0 ? 32'h02 : 32'h00);
                rdc(A_XP, 32'hC0 | 32'(p));
            end
        end
        upper_port_pins <= 4'h8;
        repeat (4) @(posedge clk);
        acc(1'b1, A_MAIN, 32'h00);
        rdc(A_MAIN, 32'h01);
        port_read <= 1'b1;
        @(posedge clk);
        port_read <= 1'b0;
        acc(1'b1, A_MAIN, 32'h00);
        rdc(A_MAIN, 32'h00);
    endtask

    task automatic t_irq();
        acc(1'b1, A_MAIN, 32'h20);
        pulse_ev(12'h800);
        repeat (4) @(posedge clk);
        chk(32'(irq_req.request), 32'h0);
        acc(1'b1, A_MAIN, 32'hA4);
        wait_req(1'b1);
        chk(32'(irq_req.vector), 32'h8);
        wait_req(1'b0);
        rdc(A_MAIN, 32'h24);
        acc(1'b1, A_MAIN, 32'h20);
        irq_return <= 1'b1;
        @(posedge clk);
        irq_return <= 1'b0;
        rdc(A_MAIN, 32'hA0);
        ack_delay <= 4'h5;
        acc(1'b1, `ICF_ADDR_RESET_CTRL, 32'h80);
        acc(1'b1, A_EP, 32'hF1);
        acc(1'b1, A_MAIN, 32'hA4);
        repeat (4) @(posedge clk);
        chk(32'(irq_req.request), 32'h0);
        acc(1'b1, A_MAIN, 32'h64);
        wait_req(1'b1);
        chk(32'(irq_req.vector), 32'h18);
        chk(32'(irq_req.high_priority), 32'h0);
        wait_req(1'b0);
        rdc(A_MAIN, 32'h24);
        acc(1'b1, A_EP, 32'hF5);
        acc(1'b1, A_MAIN, 32'hA4);
        wait_req(1'b1);
        chk(32'(irq_req.vector), 32'h8);
        wait_req(1'b0);
        rdc(A_MAIN, 32'h24);
    endtask

    initial begin
        fails = 0;
        total_checks = 0;
        rstn = 1'b0;
        {psel, penable, pwrite, port_read, rx_read, tx_write, pwm_mode, irq_return} = '0;
        paddr = 12'h000;
        pwdata = 32'h0;
        events = '0;
        ext_pins = 3'b000;
        upper_port_pins = 4'h0;
        port_latch = 8'hA5;
        ack_delay = 4'h0;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        t_regs();
        t_periph();
        t_pins();
        t_irq();
        conclude();
    end
endmodule // tb_interrupt_control_flags

// file: hw/icf_defines.svh
`ifndef ICF_DEFINES_SVH
`define ICF_DEFINES_SVH

// =============================================
// Register byte addresses
`define ICF_ADDR_MAIN       12'h000
`define ICF_ADDR_EDGE_PRIO  12'h004
`define ICF_ADDR_EXT_PINS   12'h008
`define ICF_ADDR_PERIPH_ONE 12'h00C
`define ICF_ADDR_PERIPH_EN  12'h010
`define ICF_ADDR_RESET_CTRL 12'h014
`define ICF_ADDR_VECTOR     12'h018

// =============================================
// Main control register fields
`define ICF_MAIN_GLOBAL_HIGH   7
`define ICF_MAIN_PERIPH_LOW    6
`define ICF_MAIN_TMR0_EN       5
`define ICF_MAIN_EXT0_EN       4
`define ICF_MAIN_PORT_EN       3
`define ICF_MAIN_TMR0_FLAG     2
`define ICF_MAIN_EXT0_FLAG     1
`define ICF_MAIN_PORT_FLAG     0

// =============================================
// Edge and priority register fields
`define ICF_EP_PULLUP_DIS      7
`define ICF_EP_EDGE0           6
`define ICF_EP_EDGE1           5
`define ICF_EP_EDGE2           4
`define ICF_EP_TMR0_PRIO       2
`define ICF_EP_PORT_PRIO       0

// =============================================
// External pin register fields
`define ICF_XP_EXT2_PRIO       7
`define ICF_XP_EXT1_PRIO       6
`define ICF_XP_EXT2_EN         4
`define ICF_XP_EXT1_EN         3
`define ICF_XP_EXT2_FLAG       1
`define ICF_XP_EXT1_FLAG       0

// =============================================
// Reset values and masks
`define ICF_RST_MAIN        8'h00
`define ICF_RST_EDGE_PRIO   8'hF5
`define ICF_RST_EXT_PINS    8'hC0
`define ICF_RST_PERIPH_ONE  8'h00
`define ICF_RST_PERIPH_EN   8'h00
`define ICF_RST_PRIO_ON     1'b0
`define ICF_MASK_EDGE_PRIO  8'hF5
`define ICF_MASK_EXT_PINS   8'hDB
`define ICF_PRIO_ON_BIT     7

// =============================================
// Vector addresses
`define ICF_VEC_HIGH        24'h000008
`define ICF_VEC_LOW         24'h000018

`endif

// file: hw/icf_edge_detect.sv
`timescale 1ns/1ps
`include "icf_defines.svh"

module icf_edge_detect (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic [2:0] pin,
    input  wire logic [2:0] rising_sel,
    output logic      [2:0] hit
);

    logic [2:0] prev_q;

    // =============================================
    // Per pin edge selection
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prev_q <= 3'h0;
        end else begin
            prev_q <= pin;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_pin
            assign hit[gi] = rising_sel[gi] ? (pin[gi] & ~prev_q[gi])
                                            : (~pin[gi] & prev_q[gi]);
        end
    endgenerate

endmodule // icf_edge_detect

// file: hw/icf_interrupt_flags.sv
// Local design decisions: register access over APB and the address map.
`timescale 1ns/1ps
`include "icf_defines.svh"

// Overview of operation
// - Flags set regardless of any enable bit
// - Bit7 global, or high-priority enable
// - Bit6 peripheral, or low-priority enable
// - Main bits 5,4,3 are source enables
// - Timer zero and pin zero flags
// - Port change flag on upper-pin mismatch
// - Mismatch keeps flag set until port read
// - Bit7 disables pull-ups, else latch decides
// - Edge select per external pin
// - Timer zero and port change priorities
// - Second register bits 3,1 read zero
// - Pin two/one priorities reset to one
// - Pin two/one enables
// - Pin two/one flags; bits 5,2 zero
// - Parallel port flag, software cleared
// - Conversion done flag, software cleared
// - Receive full flag, read only
// - Transmit empty flag, read only
// - Sync serial done flag
// - Capture or compare flag, unused pulse-width
// - Timer two match, timer one overflow flags
// - Priority levels only when enable bit set
// - Request vector, clear global (high) or peripheral (low) enable on response
module icf_interrupt_flags (
    input  wire logic                   clk,
    input  wire logic                   rstn,
    input  wire logic [11:0]            paddr,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire icf_pkg::icf_events_type events,
    input  wire logic [2:0]             ext_pins,
    input  wire logic [3:0]             upper_port_pins,
    input  wire logic [7:0]             port_latch,
    input  wire logic                   port_read,
    input  wire logic                   serial_rx_buffer_read,
    input  wire logic                   serial_tx_buffer_write,
    input  wire logic                   pulse_width_mode,
    input  wire logic                   irq_ack,
    input  wire logic                   irq_return,
    output icf_pkg::icf_request_type    irq_req,
    output logic      [7:0]             pullup_en
);

    // =============================================
    // Registers
    logic [7:0] main_q;
    logic [7:0] edge_prio_q;
    logic [7:0] ext_pins_q;
    logic [7:0] periph_flags_q;
    logic [7:0] periph_en_q;
    logic [7:0] periph_prio_q;
    logic       prio_levels_on_q;
    logic       rx_full_q;
    logic       tx_empty_q;
    logic       last_high_q;
    icf_pkg::icf_state_type state_q;

    // =============================================
    // Bus decode
    logic       wr_en;
    logic       addr_ok;
    logic [7:0] wbyte;

    assign wr_en = psel && penable && pwrite;
    assign wbyte = pwdata[7:0];
    assign addr_ok = (paddr == `ICF_ADDR_MAIN) || (paddr == `ICF_ADDR_EDGE_PRIO) ||
                     (paddr == `ICF_ADDR_EXT_PINS) || (paddr == `ICF_ADDR_PERIPH_ONE) ||
                     (paddr == `ICF_ADDR_PERIPH_EN) || (paddr == `ICF_ADDR_RESET_CTRL) ||
                     (paddr == `ICF_ADDR_VECTOR);

    logic wr_main;
    logic wr_ep;
    logic wr_xp;
    logic wr_p1;
    assign wr_main = wr_en && (paddr == `ICF_ADDR_MAIN);
    assign wr_ep   = wr_en && (paddr == `ICF_ADDR_EDGE_PRIO);
    assign wr_xp   = wr_en && (paddr == `ICF_ADDR_EXT_PINS);
    assign wr_p1   = wr_en && (paddr == `ICF_ADDR_PERIPH_ONE);

    // =============================================
    // Event sources
    logic [2:0] edge_hit;
    logic       port_mismatch;

    icf_edge_detect u_edge (
        .clk        (clk),
        .rstn       (rstn),
        .pin        (ext_pins),
        .rising_sel ({edge_prio_q[`ICF_EP_EDGE2], edge_prio_q[`ICF_EP_EDGE1],
                      edge_prio_q[`ICF_EP_EDGE0]}),
        .hit        (edge_hit)
    );

    icf_port_change u_port (
        .clk             (clk),
        .rstn            (rstn),
        .upper_port_pins (upper_port_pins),
        .port_read       (port_read),
        .mismatch        (port_mismatch)
    );

    logic ack_high;
    logic ack_low;
    assign ack_high = irq_ack && state_q == icf_pkg::ICF_REQ_HIGH;
    assign ack_low  = irq_ack && state_q == icf_pkg::ICF_REQ_LOW;

    // =============================================
    // Main control register
    logic [7:0] main_d;
    always_comb begin
        main_d = wr_main ? wbyte : main_q;
        main_d[`ICF_MAIN_TMR0_FLAG] |= events.timer_zero_overflow;
        main_d[`ICF_MAIN_EXT0_FLAG] |= edge_hit[0];
        main_d[`ICF_MAIN_PORT_FLAG] |= port_mismatch;
        if (ack_high) begin
            main_d[`ICF_MAIN_GLOBAL_HIGH] = 1'b0;
        end
        if (ack_low) begin
            main_d[`ICF_MAIN_PERIPH_LOW] = 1'b0;
        end
        // Return re-opens whichever enable the response closed
        if (irq_return) begin
            if (last_high_q || !prio_levels_on_q) begin
                main_d[`ICF_MAIN_GLOBAL_HIGH] = 1'b1;
            end else begin
                main_d[`ICF_MAIN_PERIPH_LOW] = 1'b1;
            end
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            main_q <= `ICF_RST_MAIN;
        end else begin
            main_q <= main_d;
        end
    end

    // =============================================
    // Edge and priority register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            edge_prio_q <= `ICF_RST_EDGE_PRIO;
        end else if (wr_ep) begin
            edge_prio_q <= wbyte & `ICF_MASK_EDGE_PRIO;
        end
    end

    // =============================================
    // External pin register
    logic [7:0] ext_pins_d;
    always_comb begin
        ext_pins_d = wr_xp ? (wbyte & `ICF_MASK_EXT_PINS) : ext_pins_q;
        ext_pins_d[`ICF_XP_EXT2_FLAG] |= edge_hit[2];
        ext_pins_d[`ICF_XP_EXT1_FLAG] |= edge_hit[1];
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ext_pins_q <= `ICF_RST_EXT_PINS;
        end else begin
            ext_pins_q <= ext_pins_d;
        end
    end

    // =============================================
    // First peripheral flag register
    logic [7:0] periph_flags_d;
    always_comb begin
        periph_flags_d = wr_p1 ? wbyte : periph_flags_q;
        periph_flags_d[7] |= events.parallel_port_access;
        periph_flags_d[6] |= events.conversion_done;
        periph_flags_d[5] = 1'b0;
        periph_flags_d[4] = 1'b0;
        periph_flags_d[3] |= events.sync_serial_done;
        periph_flags_d[2] |= events.capture_compare & ~pulse_width_mode;
        periph_flags_d[1] |= events.timer_two_match;
        periph_flags_d[0] |= events.timer_one_overflow;
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            periph_flags_q <= `ICF_RST_PERIPH_ONE;
        end else begin
            periph_flags_q <= periph_flags_d;
        end
    end

    // Read-only buffer status, driven by the serial unit
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rx_full_q  <= 1'b0;
            tx_empty_q <= 1'b1;
        end else begin
            rx_full_q  <= events.serial_rx_full |
                          (rx_full_q & ~serial_rx_buffer_read);
            tx_empty_q <= events.serial_tx_empty |
                          (tx_empty_q & ~serial_tx_buffer_write);
        end
    end

    // =============================================
    // Peripheral enables, priorities and priority mode
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            periph_en_q      <= `ICF_RST_PERIPH_EN;
            periph_prio_q    <= 8'hFF;
            prio_levels_on_q <= `ICF_RST_PRIO_ON;
        end else if (wr_en && paddr == `ICF_ADDR_PERIPH_EN) begin
            periph_en_q   <= wbyte;
            periph_prio_q <= pwdata[15:8];
        end else if (wr_en && paddr == `ICF_ADDR_RESET_CTRL) begin
            prio_levels_on_q <= wbyte[`ICF_PRIO_ON_BIT];
        end
    end

    // =============================================
    // Request evaluation
    logic [7:0] p1_view;
    logic [7:0] p_pend;
    logic [4:0] core_pend;
    logic [4:0] core_prio;
    logic       any_high;
    logic       any_low;

    assign p1_view = {periph_flags_q[7:6], rx_full_q, tx_empty_q, periph_flags_q[3:0]};
    assign p_pend  = p1_view & periph_en_q;
    assign core_pend = {main_q[`ICF_MAIN_TMR0_FLAG] & main_q[`ICF_MAIN_TMR0_EN],
                        main_q[`ICF_MAIN_EXT0_FLAG] & main_q[`ICF_MAIN_EXT0_EN],
                        main_q[`ICF_MAIN_PORT_FLAG] & main_q[`ICF_MAIN_PORT_EN],
                        ext_pins_q[`ICF_XP_EXT2_FLAG] & ext_pins_q[`ICF_XP_EXT2_EN],
                        ext_pins_q[`ICF_XP_EXT1_FLAG] & ext_pins_q[`ICF_XP_EXT1_EN]};
    // Pin zero has no priority bit: always high
    assign core_prio = {edge_prio_q[`ICF_EP_TMR0_PRIO], 1'b1, edge_prio_q[`ICF_EP_PORT_PRIO],
                        ext_pins_q[`ICF_XP_EXT2_PRIO], ext_pins_q[`ICF_XP_EXT1_PRIO]};

    always_comb begin
        if (!prio_levels_on_q) begin
            // Single-level: priority bits ignored, one vector
            any_high = main_q[`ICF_MAIN_GLOBAL_HIGH] &&
                       ((|core_pend) || (main_q[`ICF_MAIN_PERIPH_LOW] && (|p_pend)));
            any_low  = 1'b0;
        end else begin
            any_high = main_q[`ICF_MAIN_GLOBAL_HIGH] &&
                       ((|(core_pend & core_prio)) || (|(p_pend & periph_prio_q)));
            // Low level is also held off while a high request waits for its ack
            any_low  = main_q[`ICF_MAIN_PERIPH_LOW] && !(state_q == icf_pkg::ICF_REQ_HIGH) &&
                       ((|(core_pend & ~core_prio)) || (|(p_pend & ~periph_prio_q)));
        end
    end

    // =============================================
    // Request state machine
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q     <= icf_pkg::ICF_IDLE;
            irq_req     <= '0;
            last_high_q <= 1'b0;
        end else begin
            unique case (state_q)
                icf_pkg::ICF_IDLE: begin
                    if (any_high) begin
                        state_q <= icf_pkg::ICF_REQ_HIGH;
                        irq_req <= '{request: 1'b1, high_priority: 1'b1,
                                     vector: `ICF_VEC_HIGH};
                    end else if (any_low) begin
                        state_q <= icf_pkg::ICF_REQ_LOW;
                        irq_req <= '{request: 1'b1, high_priority: 1'b0, vector: `ICF_VEC_LOW};
                    end
                end
                icf_pkg::ICF_REQ_HIGH, icf_pkg::ICF_REQ_LOW: begin
                    if (irq_ack) begin
                        last_high_q <= (state_q == icf_pkg::ICF_REQ_HIGH);
                        state_q     <= icf_pkg::ICF_IDLE;
                        irq_req     <= '0;
                    end else if (state_q == icf_pkg::ICF_REQ_LOW && any_high) begin
                        state_q <= icf_pkg::ICF_REQ_HIGH;
                        irq_req <= '{request: 1'b1, high_priority: 1'b1, vector: `ICF_VEC_HIGH};
                    end else if (!any_high && !any_low) begin
                        state_q <= icf_pkg::ICF_IDLE;
                        irq_req <= '0;
                    end
                end
                default: begin
                    state_q <= icf_pkg::ICF_IDLE;
                    irq_req <= '0;
                end
            endcase
        end
    end

    // =============================================
    // Pull-up control
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pullup_en <= 8'h00;
        end else begin
            pullup_en <= edge_prio_q[`ICF_EP_PULLUP_DIS] ? 8'h00 : port_latch;
        end
    end

    // =============================================
    // Read data, wait state free
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok;
            prdata  <= 32'h0;
            if (psel && !penable && !pwrite) begin
                unique case (paddr)
                    `ICF_ADDR_MAIN:       prdata <= {24'h0, main_q};
                    `ICF_ADDR_EDGE_PRIO:  prdata <= {24'h0, edge_prio_q};
                    `ICF_ADDR_EXT_PINS:   prdata <= {24'h0, ext_pins_q};
                    `ICF_ADDR_PERIPH_ONE: prdata <= {24'h0, p1_view};
                    `ICF_ADDR_PERIPH_EN:  prdata <= {16'h0, periph_prio_q, periph_en_q};
                    `ICF_ADDR_RESET_CTRL: prdata <= {24'h0, prio_levels_on_q, 7'h00};
                    `ICF_ADDR_VECTOR:     prdata <= {6'h00, state_q, irq_req.vector};
                    default:              prdata <= 32'h0;
                endcase
            end
        end
    end

endmodule // icf_interrupt_flags

// file: hw/icf_pkg.sv
package icf_pkg;

    typedef struct packed {
        logic       timer_zero_overflow;
        logic       ext_pin_zero_edge;
        logic       ext_pin_one_edge;
        logic       ext_pin_two_edge;
        logic       parallel_port_access;
        logic       conversion_done;
        logic       serial_rx_full;
        logic       serial_tx_empty;
        logic       sync_serial_done;
        logic       capture_compare;
        logic       timer_two_match;
        logic       timer_one_overflow;
    } icf_events_type;

    typedef struct packed {
        logic        request;
        logic        high_priority;
        logic [23:0] vector;
    } icf_request_type;

    typedef enum logic [1:0] {
        ICF_IDLE      = 2'b00,
        ICF_REQ_HIGH  = 2'b01,
        ICF_REQ_LOW   = 2'b10
    } icf_state_type;

endpackage

// file: hw/icf_port_change.sv
`timescale 1ns/1ps

module icf_port_change (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic [3:0] upper_port_pins,
    input  wire logic       port_read,
    output logic            mismatch
);

    // Latched on each port read; a read ends the mismatch
    logic [3:0] snap_q;
    logic       armed_q;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            snap_q  <= 4'h0;
            armed_q <= 1'b0;
        end else if (port_read || !armed_q) begin
            snap_q  <= upper_port_pins;
            armed_q <= 1'b1;
        end
    end

    assign mismatch = armed_q && (snap_q != upper_port_pins);

endmodule // icf_port_change
